/* File: bench/dpts_link_sva.sv */
/*
 * Link checker for the page transaction sequencer.
 * Assumes the testbench wires it beside the link interface.
 */
`timescale 1ns/1ps
`default_nettype none
module dpts_link_sva
    import dpts_pkg::*;
#(
    parameter int WD_CYC = DPTS_WD_CYC,
    parameter int RD_CYC = DPTS_RD_CYC,
    parameter int RAS_CYC = DPTS_RAS_CYC,
    parameter int RCDR_CYC = DPTS_RCDR_CYC,
    parameter int RCDW_CYC = DPTS_RCDW_CYC,
    parameter int WRP_CYC = DPTS_WRP_CYC,
    parameter int RDP_CYC = DPTS_RDP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic row_activate_cmd,
    input wire logic [DPTS_BANK_W-1:0] act_bank,
    input wire logic pre_cmd,
    input wire logic [DPTS_BANK_W-1:0] pre_bank,
    input wire logic col_cmd,
    input wire logic col_write,
    input wire logic [DPTS_BANK_W-1:0] col_bank,
    input wire logic wdat_valid,
    input wire logic rdat_valid
);
    // ============================================================
    // Cycles since last activate and last column
    logic [7:0] since_act_q, since_act_d, since_col_q, since_col_d;
    always_comb begin
        since_act_d = row_activate_cmd ? 8'h01 : since_act_q + {7'h00, since_act_q != 8'hFF};
        since_col_d = col_cmd ? 8'h01 : since_col_q + {7'h00, since_col_q != 8'hFF};
    end
    always_ff @(posedge clk) begin
        since_act_q <= rst ? 8'hFF : since_act_d;
        since_col_q <= rst ? 8'hFF : since_col_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ============================================================
    // Assertions
    AST_WDAT_DELAY: assert property (col_cmd && col_write |-> ##WD_CYC wdat_valid)
        else $error("write data not at write data delay");
    AST_RDAT_DELAY: assert property (col_cmd && !col_write |-> ##RD_CYC rdat_valid)
        else $error("read data not at read data delay");
    AST_WDAT_LEN: assert property ($rose(wdat_valid) |-> wdat_valid[*2])
        else $error("write packet too short");
    AST_RDAT_LEN: assert property ($rose(rdat_valid) |-> rdat_valid[*2])
        else $error("read packet too short");
    AST_COL_SPACE: assert property (col_cmd |=> !col_cmd)
        else $error("columns too close");
    AST_PRE_ACT: assert property (pre_cmd |=> !(row_activate_cmd && act_bank == pre_bank)[*5])
        else $error("activate too soon after precharge");
    AST_ACT_RD: assert property (row_activate_cmd
        |=> !(col_cmd && !col_write && col_bank == act_bank)[*4])
        else $error("read too soon after activate");
    AST_WR_PRE: assert property (pre_cmd && pre_bank == col_bank && col_write |-> since_col_q >= WRP_CYC)
        else $error("precharge too soon after write");
    AST_RD_PRE: assert property (pre_cmd && pre_bank == col_bank && !col_write
        |-> since_col_q >= RDP_CYC)
        else $error("precharge too soon after read");
    AST_RAS: assert property (pre_cmd && pre_bank == act_bank |-> since_act_q >= RAS_CYC)
        else $error("precharge too soon after activate");
    AST_WR_ACT_PRE: assert property (pre_cmd && pre_bank == act_bank
        && pre_bank == col_bank && col_write |-> since_act_q >= RCDW_CYC + WRP_CYC)
        else $error("write row active too short");
    AST_RD_ACT_PRE: assert property (pre_cmd && pre_bank == act_bank
        && pre_bank == col_bank && !col_write |-> since_act_q >= RCDR_CYC + RDP_CYC)
        else $error("read row active too short");
    cover property (col_cmd && col_write);
    cover property (col_cmd && !col_write);
    cover property (pre_cmd ##[1:8] row_activate_cmd);
endmodule : dpts_link_sva
`default_nettype wire

/* File: bench/dram_page_transaction_sequencer_tb_top.sv */
/*
 * Testbench joining controller and memory ends over the link.
 * Assumes default timing parameters and one 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dram_page_transaction_sequencer_tb_top;
    import dpts_pkg::*;
    logic clk, rst, close_policy, req_valid, req_write, req_ready, rsp_valid, proto_err, wv_q;
    logic [DPTS_BANK_W-1:0] req_bank;
    logic [DPTS_ROW_W-1:0] req_row;
    logic [DPTS_COL_W-1:0] req_col;
    logic [DPTS_DATA_W-1:0] req_wdata, rsp_data, wd_seen, rd_seen;
    int num_errors = 0, tests_run = 0, cyc = 0, n_act = 0, n_pre = 0, d_act, d_pre;
    int t_act, t_pre, t_col, t_wd, t_rsp;
    dpts_link_if u_dpts_link_if ();
    dpts_ctrl_end u_dpts_ctrl_end (.clk(clk), .rst(rst), .close_policy(close_policy), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(u_dpts_link_if.ctrl));
    dpts_mem_end u_dpts_mem_end (.clk(clk), .rst(rst), .link(u_dpts_link_if.mem), .proto_err(proto_err));
    dpts_link_sva u_dpts_link_sva (.clk(clk), .rst(rst), .row_activate_cmd(u_dpts_link_if.row_activate_cmd),
        .act_bank(u_dpts_link_if.act_bank), .pre_cmd(u_dpts_link_if.pre_cmd), .pre_bank(u_dpts_link_if.pre_bank),
        .col_cmd(u_dpts_link_if.col_cmd), .col_write(u_dpts_link_if.col_write),
        .col_bank(u_dpts_link_if.col_bank), .wdat_valid(u_dpts_link_if.wdat_valid),
        .rdat_valid(u_dpts_link_if.rdat_valid));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ============================================================
    // Link monitor and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        wv_q <= u_dpts_link_if.wdat_valid;
        if (u_dpts_link_if.row_activate_cmd === 1'b1) begin
            n_act <= n_act + 1;
            t_act <= cyc;
        end
        if (u_dpts_link_if.pre_cmd === 1'b1) begin
            n_pre <= n_pre + 1;
            t_pre <= cyc;
        end
        if (u_dpts_link_if.col_cmd === 1'b1) begin
            t_col <= cyc;
        end
        if (u_dpts_link_if.wdat_valid === 1'b1 && wv_q !== 1'b1) begin
            wd_seen <= u_dpts_link_if.wdat;
            t_wd <= cyc;
        end
        if (rsp_valid === 1'b1) begin
            rd_seen <= rsp_data;
            t_rsp <= cyc;
        end
        if (cyc == 4000) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end
    // ============================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic ge(input string name, input logic cond);
        check(name, {15'h0000, cond}, 16'h0001);
    endtask : ge
    task automatic do_req(input logic w, input logic [2:0] b, input logic [3:0] r, input logic [3:0] c,
        input logic [15:0] d, input logic p);
        int a0, p0;
        @(posedge clk);
        a0 = n_act;
        p0 = n_pre;
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= b;
        req_row <= r;
        req_col <= c;
        req_wdata <= d;
        close_policy <= p;
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        @(posedge clk);
        check("ready after take", {15'h0000, req_ready}, 16'h0000);
        while (req_ready !== 1'b1) @(posedge clk);
        repeat (12) @(posedge clk);
        d_act = n_act - a0;
        d_pre = n_pre - p0;
    endtask : do_req
    task automatic rows(input int a, input int p);
        check("activates", 16'(d_act), 16'(a));
        check("precharges", 16'(d_pre), 16'(p));
    endtask : rows
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // ============================================================
    // Scenarios
    task automatic s_empty_write();
        do_req(1'b1, 3'h1, 4'h3, 4'h5, 16'hA5C3, 1'b0);
        rows(1, 0);
        check("write data", wd_seen, 16'hA5C3);
        check("write delay", 16'(t_wd - t_col), 16'(DPTS_WD_CYC));
        $display("test empty write done");
    endtask : s_empty_write
    task automatic s_hit_read();
        do_req(1'b0, 3'h1, 4'h3, 4'h5, 16'h0000, 1'b0);
        rows(0, 0);
        check("read data", rd_seen, 16'hA5C3);
        check("read delay", 16'(t_rsp - t_col), 16'(DPTS_RD_CYC + 1));
        $display("test hit read done");
    endtask : s_hit_read
    task automatic s_hit_write();
        do_req(1'b1, 3'h1, 4'h3, 4'h6, 16'h1234, 1'b0);
        rows(0, 0);
        check("write data", wd_seen, 16'h1234);
        $display("test hit write done");
    endtask : s_hit_write
    task automatic s_miss_read();
        do_req(1'b0, 3'h1, 4'h7, 4'h5, 16'h0000, 1'b0);
        rows(1, 1);
        ge("pre to act", t_act - t_pre >= DPTS_RP_CYC);
        ge("act to col", t_col - t_act >= DPTS_RCDR_CYC);
        do_req(1'b0, 3'h1, 4'h3, 4'h6, 16'h0000, 1'b0);
        rows(1, 1);
        check("read back", rd_seen, 16'h1234);
        $display("test miss read done");
    endtask : s_miss_read
    task automatic s_close();
        do_req(1'b1, 3'h2, 4'h1, 4'h0, 16'hBEEF, 1'b1);
        rows(1, 1);
        ge("write to pre", t_pre - t_col >= DPTS_WRP_CYC);
        ge("write act to pre", t_pre - t_act >= DPTS_RCDW_CYC + DPTS_WRP_CYC);
        do_req(1'b0, 3'h2, 4'h1, 4'h0, 16'h0000, 1'b1);
        rows(1, 1);
        check("closed read", rd_seen, 16'hBEEF);
        ge("read to pre", t_pre - t_col >= DPTS_RDP_CYC);
        ge("row active", t_pre - t_act >= DPTS_RAS_CYC);
        ge("read act to pre", t_pre - t_act >= DPTS_RCDR_CYC + DPTS_RDP_CYC);
        $display("test close policy done");
    endtask : s_close
    initial begin
        rst = 1'b1;
        close_policy = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_bank = 3'h0;
        req_row = 4'h0;
        req_col = 4'h0;
        req_wdata = 16'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        s_empty_write();
        s_hit_read();
        s_hit_write();
        s_miss_read();
        s_close();
        check("protocol error", {15'h0000, proto_err}, 16'h0000);
        finish_test();
    end
endmodule : dram_page_transaction_sequencer_tb_top
`default_nettype wire

/* File: core/dpts_ctrl_end.sv */
/*
 * Controller end: takes single-column requests, classifies them against
 * per-bank open state and issues precharge, activate and column packets
 * under per-bank spacing timers and one shared column timer; drives write data and returns read data.
 * Assumes the memory end on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dpts_ctrl_end
    import dpts_pkg::*;
#(
    parameter int CC_CYC = DPTS_CC_CYC,
    parameter int WD_CYC = DPTS_WD_CYC,
    parameter int RD_CYC = DPTS_RD_CYC,
    parameter int RP_CYC = DPTS_RP_CYC,
    parameter int RCDR_CYC = DPTS_RCDR_CYC,
    parameter int RCDW_CYC = DPTS_RCDW_CYC,
    parameter int WRP_CYC = DPTS_WRP_CYC,
    parameter int RDP_CYC = DPTS_RDP_CYC,
    parameter int RAS_CYC = DPTS_RAS_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Page policy: high closes the bank after each access
    input wire logic close_policy,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [DPTS_BANK_W-1:0] req_bank,
    input wire logic [DPTS_ROW_W-1:0] req_row,
    input wire logic [DPTS_COL_W-1:0] req_col,
    input wire logic [DPTS_DATA_W-1:0] req_wdata,
    // Read answer
    output logic rsp_valid,
    output logic [DPTS_DATA_W-1:0] rsp_data,
    // Link
    dpts_link_if.ctrl link
);
    localparam int BANKS = 1 << DPTS_BANK_W;
    localparam logic [DPTS_TMR_W-1:0] T_CC = DPTS_TMR_W'(CC_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_RP = DPTS_TMR_W'(RP_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_RCDR = DPTS_TMR_W'(RCDR_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_RCDW = DPTS_TMR_W'(RCDW_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_WRP = DPTS_TMR_W'(WRP_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_RDP = DPTS_TMR_W'(RDP_CYC - 1);
    localparam logic [DPTS_TMR_W-1:0] T_RAS = DPTS_TMR_W'(RAS_CYC - 1);

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_PRE = 5'h02,
        S_ACT = 5'h04,
        S_COL = 5'h08,
        S_CLOSE = 5'h10
    } dpts_ctrl_state_t;

    dpts_ctrl_state_t state_q, state_d;
    logic open_q [BANKS];
    logic open_d [BANKS];
    logic [DPTS_ROW_W-1:0] row_q [BANKS];
    logic [DPTS_ROW_W-1:0] row_d [BANKS];
    logic [DPTS_TMR_W-1:0] actw_q [BANKS];
    logic [DPTS_TMR_W-1:0] actw_d [BANKS];
    logic [DPTS_TMR_W-1:0] colr_q [BANKS];
    logic [DPTS_TMR_W-1:0] colr_d [BANKS];
    logic [DPTS_TMR_W-1:0] colw_q [BANKS];
    logic [DPTS_TMR_W-1:0] colw_d [BANKS];
    logic [DPTS_TMR_W-1:0] prew_q [BANKS];
    logic [DPTS_TMR_W-1:0] prew_d [BANKS];
    logic [DPTS_TMR_W-1:0] ccw_q, ccw_d;
    logic wr_q, wr_d;
    logic [DPTS_BANK_W-1:0] bank_q, bank_d;
    logic [DPTS_ROW_W-1:0] rrow_q, rrow_d;
    logic [DPTS_COL_W-1:0] col_q, col_d;
    logic [DPTS_DATA_W-1:0] data_q, data_d;
    logic act_q, act_d, pre_q, pre_d, colc_q, colc_d, colw_o_q, colw_o_d;
    logic [DPTS_BANK_W-1:0] actb_q, actb_d, preb_q, preb_d, colb_q, colb_d;
    logic [DPTS_ROW_W-1:0] actr_q, actr_d;
    logic [DPTS_COL_W-1:0] cola_q, cola_d;
    logic wp_v_q [WD_CYC];
    logic wp_v_d [WD_CYC];
    logic [DPTS_DATA_W-1:0] wp_d_q [WD_CYC];
    logic [DPTS_DATA_W-1:0] wp_d_d [WD_CYC];
    logic rp_v_q [RD_CYC+1];
    logic rp_v_d [RD_CYC+1];
    logic wv_q, wv_d;
    logic [DPTS_DATA_W-1:0] wdat_q, wdat_d;
    logic [DPTS_TMR_W-1:0] whold_q, whold_d;
    logic rdy_q, rdy_d, rspv_q, rspv_d;
    logic [DPTS_DATA_W-1:0] rspd_q, rspd_d;
    logic [DPTS_TMR_W-1:0] gap;

    // ============================================================
    // Sequencer next state
    always_comb begin
        state_d = state_q;
        open_d = open_q;
        row_d = row_q;
        ccw_d = (ccw_q != '0) ? ccw_q - 1'b1 : ccw_q;
        for (int b = 0; b < BANKS; b++) begin
            actw_d[b] = (actw_q[b] != '0) ? actw_q[b] - 1'b1 : actw_q[b];
            colr_d[b] = (colr_q[b] != '0) ? colr_q[b] - 1'b1 : colr_q[b];
            colw_d[b] = (colw_q[b] != '0) ? colw_q[b] - 1'b1 : colw_q[b];
            prew_d[b] = (prew_q[b] != '0) ? prew_q[b] - 1'b1 : prew_q[b];
        end
        wr_d = wr_q;
        bank_d = bank_q;
        rrow_d = rrow_q;
        col_d = col_q;
        data_d = data_q;
        act_d = 1'b0;
        pre_d = 1'b0;
        colc_d = 1'b0;
        colw_o_d = colw_o_q;
        actb_d = actb_q;
        preb_d = preb_q;
        colb_d = colb_q;
        actr_d = actr_q;
        cola_d = cola_q;
        gap = wr_q ? T_WRP : T_RDP;
        case (state_q)
            S_IDLE: begin
                if (req_valid) begin
                    wr_d = req_write;
                    bank_d = req_bank;
                    rrow_d = req_row;
                    col_d = req_col;
                    data_d = req_wdata;
                    if (!open_q[req_bank]) begin
                        state_d = S_ACT;
                    end else if (row_q[req_bank] == req_row) begin
                        state_d = S_COL;
                    end else begin
                        state_d = S_PRE;
                    end
                end
            end
            S_PRE, S_CLOSE: begin
                if (prew_q[bank_q] == '0) begin
                    pre_d = 1'b1;
                    preb_d = bank_q;
                    open_d[bank_q] = 1'b0;
                    actw_d[bank_q] = T_RP;
                    state_d = (state_q == S_PRE) ? S_ACT : S_IDLE;
                end
            end
            S_ACT: begin
                if (actw_q[bank_q] == '0) begin
                    act_d = 1'b1;
                    actb_d = bank_q;
                    actr_d = rrow_q;
                    open_d[bank_q] = 1'b1;
                    row_d[bank_q] = rrow_q;
                    colr_d[bank_q] = T_RCDR;
                    colw_d[bank_q] = T_RCDW;
                    prew_d[bank_q] = T_RAS;
                    state_d = S_COL;
                end
            end
            S_COL: begin
                if (ccw_q == '0 && (wr_q ? colw_q[bank_q] : colr_q[bank_q]) == '0) begin
                    colc_d = 1'b1;
                    colw_o_d = wr_q;
                    colb_d = bank_q;
                    cola_d = col_q;
                    ccw_d = T_CC;
                    // Longer of row-active and column-to-precharge governs
                    if (gap > prew_d[bank_q]) begin
                        prew_d[bank_q] = gap;
                    end
                    state_d = close_policy ? S_CLOSE : S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        rdy_d = (state_d == S_IDLE);
    end

    // ============================================================
    // Data path next state
    always_comb begin
        wp_v_d[0] = colc_d && wr_q;
        wp_d_d[0] = data_q;
        for (int i = 1; i < WD_CYC; i++) begin
            wp_v_d[i] = wp_v_q[i-1];
            wp_d_d[i] = wp_d_q[i-1];
        end
        rp_v_d[0] = colc_d && !wr_q;
        for (int i = 1; i <= RD_CYC; i++) begin
            rp_v_d[i] = rp_v_q[i-1];
        end
        wv_d = wv_q;
        wdat_d = wdat_q;
        whold_d = whold_q;
        if (wp_v_q[WD_CYC-1]) begin
            wv_d = 1'b1;
            wdat_d = wp_d_q[WD_CYC-1];
            whold_d = T_CC;
        end else if (whold_q != '0) begin
            whold_d = whold_q - 1'b1;
        end else begin
            wv_d = 1'b0;
        end
        rspv_d = rp_v_q[RD_CYC] && link.rdat_valid;
        rspd_d = rp_v_q[RD_CYC] ? link.rdat : rspd_q;
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            for (int b = 0; b < BANKS; b++) begin
                open_q[b] <= 1'b0;
                row_q[b] <= '0;
                actw_q[b] <= '0;
                colr_q[b] <= '0;
                colw_q[b] <= '0;
                prew_q[b] <= '0;
            end
            for (int i = 0; i < WD_CYC; i++) begin
                wp_v_q[i] <= 1'b0;
                wp_d_q[i] <= '0;
            end
            for (int i = 0; i <= RD_CYC; i++) begin
                rp_v_q[i] <= 1'b0;
            end
            ccw_q <= '0;
            {wr_q, bank_q, rrow_q, col_q, data_q} <= '0;
            {act_q, pre_q, colc_q, colw_o_q} <= '0;
            {actb_q, preb_q, colb_q, actr_q, cola_q} <= '0;
            {wv_q, wdat_q, whold_q} <= '0;
            {rdy_q, rspv_q, rspd_q} <= '0;
        end else begin
            state_q <= state_d;
            open_q <= open_d;
            row_q <= row_d;
            actw_q <= actw_d;
            colr_q <= colr_d;
            colw_q <= colw_d;
            prew_q <= prew_d;
            wp_v_q <= wp_v_d;
            wp_d_q <= wp_d_d;
            rp_v_q <= rp_v_d;
            ccw_q <= ccw_d;
            {wr_q, bank_q, rrow_q, col_q, data_q} <= {wr_d, bank_d, rrow_d, col_d, data_d};
            {act_q, pre_q, colc_q, colw_o_q} <= {act_d, pre_d, colc_d, colw_o_d};
            {actb_q, preb_q, colb_q, actr_q, cola_q} <= {actb_d, preb_d, colb_d, actr_d, cola_d};
            {wv_q, wdat_q, whold_q} <= {wv_d, wdat_d, whold_d};
            {rdy_q, rspv_q, rspd_q} <= {rdy_d, rspv_d, rspd_d};
        end
    end

    assign req_ready = rdy_q;
    assign rsp_valid = rspv_q;
    assign rsp_data = rspd_q;
    assign link.row_activate_cmd = act_q;
    assign link.act_bank = actb_q;
    assign link.act_row = actr_q;
    assign link.pre_cmd = pre_q;
    assign link.pre_bank = preb_q;
    assign link.col_cmd = colc_q;
    assign link.col_write = colw_o_q;
    assign link.col_bank = colb_q;
    assign link.col_addr = cola_q;
    assign link.wdat_valid = wv_q;
    assign link.wdat = wdat_q;
endmodule : dpts_ctrl_end
`default_nettype wire

/* File: core/dpts_link_if.sv */
/*
 * Request and data link between controller and memory device.
 * Assumes both ends run on one clock; every signal is driven by a flop.
 */
`timescale 1ns/1ps
`default_nettype none
interface dpts_link_if;
    import dpts_pkg::*;
    // Activate request
    logic row_activate_cmd;
    logic [DPTS_BANK_W-1:0] act_bank;
    logic [DPTS_ROW_W-1:0] act_row;
    // Precharge request
    logic pre_cmd;
    logic [DPTS_BANK_W-1:0] pre_bank;
    // Column request
    logic col_cmd;
    logic col_write;
    logic [DPTS_BANK_W-1:0] col_bank;
    logic [DPTS_COL_W-1:0] col_addr;
    // Data packets
    logic wdat_valid;
    logic [DPTS_DATA_W-1:0] wdat;
    logic rdat_valid;
    logic [DPTS_DATA_W-1:0] rdat;

    modport ctrl (
        output row_activate_cmd, act_bank, act_row, pre_cmd, pre_bank,
        output col_cmd, col_write, col_bank, col_addr, wdat_valid, wdat,
        input rdat_valid, rdat
    );
    modport mem (
        input row_activate_cmd, act_bank, act_row, pre_cmd, pre_bank,
        input col_cmd, col_write, col_bank, col_addr, wdat_valid, wdat,
        output rdat_valid, rdat
    );
endinterface : dpts_link_if
`default_nettype wire

/* File: core/dpts_mem_end.sv */
/*
 * Memory device end: banks with open rows, column reads and writes,
 * data packets at fixed delays after each column packet.
 * Assumes the controller keeps all row and column spacing itself.
 */
`timescale 1ns/1ps
`default_nettype none
module dpts_mem_end
    import dpts_pkg::*;
#(
    parameter int CC_CYC = DPTS_CC_CYC,
    parameter int WD_CYC = DPTS_WD_CYC,
    parameter int RD_CYC = DPTS_RD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    dpts_link_if.mem link,
    // Status
    output logic proto_err
);
    localparam int BANKS = 1 << DPTS_BANK_W;
    localparam int AW = DPTS_BANK_W + DPTS_ROW_W + DPTS_COL_W;

    logic [DPTS_DATA_W-1:0] mem_q [0:(1<<AW)-1];
    logic open_q [BANKS];
    logic open_d [BANKS];
    logic [DPTS_ROW_W-1:0] row_q [BANKS];
    logic [DPTS_ROW_W-1:0] row_d [BANKS];
    logic wp_v_q [WD_CYC];
    logic wp_v_d [WD_CYC];
    logic [AW-1:0] wp_a_q [WD_CYC];
    logic [AW-1:0] wp_a_d [WD_CYC];
    logic rp_v_q [RD_CYC-1];
    logic rp_v_d [RD_CYC-1];
    logic [DPTS_DATA_W-1:0] rp_d_q [RD_CYC-1];
    logic [DPTS_DATA_W-1:0] rp_d_d [RD_CYC-1];
    logic rv_q, rv_d;
    logic [DPTS_DATA_W-1:0] rdat_q, rdat_d;
    logic [DPTS_TMR_W-1:0] hold_q, hold_d;
    logic err_q, err_d;
    logic [AW-1:0] col_a;
    logic col_ok;

    // ============================================================
    // Next state
    always_comb begin
        open_d = open_q;
        row_d = row_q;
        err_d = err_q;
        if (link.pre_cmd) begin
            open_d[link.pre_bank] = 1'b0;
        end
        if (link.row_activate_cmd) begin
            if (open_q[link.act_bank]) begin
                err_d = 1'b1;
            end
            open_d[link.act_bank] = 1'b1;
            row_d[link.act_bank] = link.act_row;
        end
        // Column goes straight to the open row of its bank
        col_a = {link.col_bank, row_q[link.col_bank], link.col_addr};
        col_ok = link.col_cmd && open_q[link.col_bank];
        if (link.col_cmd && !open_q[link.col_bank]) begin
            err_d = 1'b1;
        end
        // Write capture position tracker
        wp_v_d[0] = col_ok && link.col_write;
        wp_a_d[0] = col_a;
        for (int i = 1; i < WD_CYC; i++) begin
            wp_v_d[i] = wp_v_q[i-1];
            wp_a_d[i] = wp_a_q[i-1];
        end
        // Read data pipeline
        rp_v_d[0] = col_ok && !link.col_write;
        rp_d_d[0] = mem_q[col_a];
        for (int i = 1; i < RD_CYC - 1; i++) begin
            rp_v_d[i] = rp_v_q[i-1];
            rp_d_d[i] = rp_d_q[i-1];
        end
        // Read packet held for one column cycle
        rv_d = rv_q;
        rdat_d = rdat_q;
        hold_d = hold_q;
        if (rp_v_q[RD_CYC-2]) begin
            rv_d = 1'b1;
            rdat_d = rp_d_q[RD_CYC-2];
            hold_d = DPTS_TMR_W'(CC_CYC - 1);
        end else if (hold_q != '0) begin
            hold_d = hold_q - 1'b1;
        end else begin
            rv_d = 1'b0;
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int b = 0; b < BANKS; b++) begin
                open_q[b] <= 1'b0;
                row_q[b] <= '0;
            end
            for (int i = 0; i < WD_CYC; i++) begin
                wp_v_q[i] <= 1'b0;
                wp_a_q[i] <= '0;
            end
            for (int i = 0; i < RD_CYC - 1; i++) begin
                rp_v_q[i] <= 1'b0;
                rp_d_q[i] <= '0;
            end
            rv_q <= 1'b0;
            rdat_q <= '0;
            hold_q <= '0;
            err_q <= 1'b0;
        end else begin
            open_q <= open_d;
            row_q <= row_d;
            wp_v_q <= wp_v_d;
            wp_a_q <= wp_a_d;
            rp_v_q <= rp_v_d;
            rp_d_q <= rp_d_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            hold_q <= hold_d;
            err_q <= err_d;
        end
    end

    // Data sampled exactly one write data delay after its column
    always_ff @(posedge clk) begin
        if (wp_v_q[WD_CYC-1] && link.wdat_valid) begin
            mem_q[wp_a_q[WD_CYC-1]] <= link.wdat;
        end
    end

    assign link.rdat_valid = rv_q;
    assign link.rdat = rdat_q;
    assign proto_err = err_q;
endmodule : dpts_mem_end
`default_nettype wire

/* File: core/dpts_pkg.sv */
/*
 * Shared constants for the page transaction sequencer: widths, request
 * cycle timing and the cycle counts derived from it.
 * Assumes a single 10 MHz clock shared by both ends.
 */
package dpts_pkg;
    // ============================================================
    // Widths
    localparam int DPTS_BANK_W = 3;
    localparam int DPTS_ROW_W = 4;
    localparam int DPTS_COL_W = 4;
    localparam int DPTS_DATA_W = 16;
    localparam int DPTS_TMR_W = 8;

    // ============================================================
    // Timing in ns
    localparam int DPTS_CLK_PERIOD_NS = 100;
    localparam int DPTS_COLUMN_CYCLE_TIME_NS = 200;
    localparam int DPTS_WRITE_DATA_DELAY_NS = 400;
    localparam int DPTS_READ_DATA_DELAY_NS = 600;
    localparam int DPTS_PRECHARGE_TO_ACTIVATE_TIME_NS = 600;
    localparam int DPTS_ROW_TO_COLUMN_READ_TIME_NS = 500;
    localparam int DPTS_ROW_TO_COLUMN_WRITE_TIME_NS = 100;
    localparam int DPTS_WRITE_TO_PRECHARGE_TIME_NS = 1100;
    localparam int DPTS_READ_TO_PRECHARGE_TIME_NS = 500;
    localparam int DPTS_MIN_ROW_ACTIVE_TIME_NS = 1000;

    // ============================================================
    // Least times, rounded up to whole cycles, at least one
    function automatic int dpts_cyc(input int ns);
        int c;
        c = (ns + DPTS_CLK_PERIOD_NS - 1) / DPTS_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : dpts_cyc

    localparam int DPTS_CC_CYC = dpts_cyc(DPTS_COLUMN_CYCLE_TIME_NS);
    localparam int DPTS_WD_CYC = dpts_cyc(DPTS_WRITE_DATA_DELAY_NS);
    localparam int DPTS_RD_CYC = dpts_cyc(DPTS_READ_DATA_DELAY_NS);
    localparam int DPTS_RP_CYC = dpts_cyc(DPTS_PRECHARGE_TO_ACTIVATE_TIME_NS);
    localparam int DPTS_RCDR_CYC = dpts_cyc(DPTS_ROW_TO_COLUMN_READ_TIME_NS);
    localparam int DPTS_RCDW_CYC = dpts_cyc(DPTS_ROW_TO_COLUMN_WRITE_TIME_NS);
    localparam int DPTS_WRP_CYC = dpts_cyc(DPTS_WRITE_TO_PRECHARGE_TIME_NS);
    localparam int DPTS_RDP_CYC = dpts_cyc(DPTS_READ_TO_PRECHARGE_TIME_NS);
    localparam int DPTS_RAS_CYC = dpts_cyc(DPTS_MIN_ROW_ACTIVE_TIME_NS);
endpackage : dpts_pkg
